// file: dv/capture_cond_props.sv
// Purpose: Port-level assertions for the capture conditioning block.
// Assumes: One clock domain; arst_n low holds the block in reset.
// Notes:   Bound to the top module below the checker.
`timescale 1ns/100ps
module capture_cond_props
	import capture_cond_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [DATA_W-1:0] reg_rdata,
	input  wire logic              ch2_raw_input,
	input  wire logic              ch3_raw_input,
	input  wire logic              internal_trigger_input,
	input  wire logic [1:0]        selected_input,
	input  wire logic [1:0]        capture_event,
	input  wire logic [1:0]        channel_is_output,
	input  wire logic [EN_W-1:0]   channel_enable_polarity
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	wire en_wr = reg_wr && reg_addr == OFF_CH_EN;
	wire en_rd = reg_rd && reg_addr == OFF_CH_EN;
	sequence s_ch2_on3;
		channel_enable_polarity[EN_CH2_ON] [*3];
	endsequence
	sequence s_ch2_off2;
		!channel_enable_polarity[EN_CH2_ON] [*2];
	endsequence

	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == '0)
		else $error("read data not zero outside a read");
	AST_EN_READ: assert property (en_rd |=> reg_rdata == {18'h0, $past(channel_enable_polarity)})
		else $error("enable register read mismatch");
	AST_EN_WRITE: assert property (en_wr |=> channel_enable_polarity == $past(reg_wdata[EN_W-1:0]))
		else $error("enable register write not taken");
	AST_EN_HOLD: assert property (!en_wr |=> $stable(channel_enable_polarity))
		else $error("enable register changed without a write");
	AST_MODE_LOCK: assert property (s_ch2_on3 |-> $stable(channel_is_output[0]))
		else $error("channel 2 mode changed while enabled");
	AST_NO_EVT_OFF: assert property (s_ch2_off2 |-> !capture_event[0])
		else $error("channel 2 event while disabled");
	AST_EVT_PULSE: assert property (capture_event[0] |=> !capture_event[0])
		else $error("channel 2 event longer than one cycle");
	AST_OUT_NO_EVT: assert property (channel_is_output[0] [*2] |-> !capture_event[0])
		else $error("channel 2 event in output mode");
	AST_EVT_EDGE2: assert property (capture_event[0] |-> $rose(selected_input[0]))
		else $error("channel 2 event without active edge");
	AST_EVT_EDGE3: assert property (capture_event[1] |-> $rose(selected_input[1]))
		else $error("channel 3 event without active edge");
endmodule : capture_cond_props

bind timer_input_capture_conditioning capture_cond_props chk (
	.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.ch2_raw_input(ch2_raw_input), .ch3_raw_input(ch3_raw_input),
	.internal_trigger_input(internal_trigger_input), .selected_input(selected_input),
	.capture_event(capture_event), .channel_is_output(channel_is_output),
	.channel_enable_polarity(channel_enable_polarity)
);

// file: dv/capture_signal_source.sv
// Purpose: Model of the external capture sources and the trigger line.
// Assumes: Sources are synchronous to clk.
// Notes:   Levels move only just after a rising edge, as a real pin would.
`timescale 1ns/100ps
module capture_signal_source (
	input  wire logic       clk,
	input  wire logic [2:0] lvl_req,
	output logic            ch2_raw,
	output logic            ch3_raw,
	output logic            trig
);
	always_ff @(posedge clk) begin
		{trig, ch3_raw, ch2_raw} <= lvl_req;
	end
endmodule : capture_signal_source

// file: dv/timer_input_capture_conditioning_tb_top.sv
// Purpose: Self-checking bench for the capture conditioning block.
// Assumes: Dead-time tick equals clk, except in the last scenario, which slows it.
// Notes:   Random values come from an 8-bit LFSR seeded with 55.
`timescale 1ns/100ps
module timer_input_capture_conditioning_tb_top;
	import capture_cond_pkg::*;
	logic              clk = 0;
	logic              arst_n = 0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic              reg_wr = 0;
	logic              reg_rd = 0;
	logic [DATA_W-1:0] reg_rdata;
	logic [2:0]        lvl = '0;
	logic              r2, r3, trg;
	logic [1:0]        sel, evt, is_out;
	logic [EN_W-1:0]   enp;
	logic [7:0]        rnd = 8'h37;
	int                miscompares = 0, n_checks = 0, ev0 = 0, ev1 = 0, b0, b1, n;

	initial forever #25 clk = ~clk;
	always @(posedge clk) begin
		if (evt[0] === 1'b1) ev0 <= ev0 + 1;
		if (evt[1] === 1'b1) ev1 <= ev1 + 1;
	end

	capture_signal_source src (.clk(clk), .lvl_req(lvl), .ch2_raw(r2), .ch3_raw(r3), .trig(trg));
	timer_input_capture_conditioning uut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ch2_raw_input(r2), .ch3_raw_input(r3), .internal_trigger_input(trg),
		.selected_input(sel), .capture_event(evt), .channel_is_output(is_out),
		.channel_enable_polarity(enp));

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	function automatic int fdiv(input logic [3:0] c);
		case (c)
			4'h4, 4'h5: return 2;
			4'h6, 4'h7: return 4;
			4'h8, 4'h9: return 8;
			4'hA, 4'hB, 4'hC: return 16;
			4'hD, 4'hE, 4'hF: return 32;
			default: return 1;
		endcase
	endfunction : fdiv
	function automatic int flen(input logic [3:0] c);
		case (c)
			4'h0: return 1;
			4'h1: return 2;
			4'h2: return 4;
			4'hA, 4'hD: return 5;
			4'h4, 4'h6, 4'h8, 4'hB, 4'hE: return 6;
			default: return 8;
		endcase
	endfunction : flen

	task automatic finish_test;
		if (miscompares == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		// One idle edge keeps back-to-back writes from reassigning the strobe at once.
		@(posedge clk);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		chk(nm, reg_rdata, exp);
	endtask : rd_chk
	// Rising edges are six cycles apart so the unfiltered path never merges two.
	task automatic edges(input logic [2:0] m, input int k);
		repeat (k) begin
			lvl <= m;
			repeat (3) @(posedge clk);
			lvl <= 3'h0;
			repeat (3) @(posedge clk);
		end
		repeat (4) @(posedge clk);
	endtask : edges
	// A wait that runs past its bound is a mismatch and ends the run.
	task automatic wait_ev(input int lo, input int hi);
		int k;
		k = 0;
		b0 = ev0;
		while (ev0 == b0 && k <= hi) begin
			@(posedge clk);
			k++;
		end
		chk("filter_latency_ok", 32'(k >= lo && k <= hi), 32'h1);
		if (k > hi) finish_test();
	endtask : wait_ev

	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk("is_output_reset", is_out, 2'h3);
		rd_chk(OFF_CH_EN, 32'h0, "en_reset");
		rd_chk(OFF_CAP_CFG, 32'h0, "cfg_reset");
		rd_chk(8'h24, 32'h0, "unmapped_read");
		wr(OFF_CH_EN, 32'h0000_3FFF);
		rd_chk(OFF_CH_EN, 32'h0000_3FFF, "en_all_ones");
		chk("en_port", enp, 32'h0000_3FFF);
		repeat (4) begin
			rnd = lfsr(rnd);
			wr(OFF_CH_EN, {18'h0, rnd[5:0] ^ 6'h25, rnd});
			rd_chk(OFF_CH_EN, {18'h0, rnd[5:0] ^ 6'h25, rnd}, "en_random");
		end
		wr(OFF_CH_EN, 32'h0000_0100);
		wr(OFF_CAP_CFG, 32'h0000_0101);
		rd_chk(OFF_CAP_CFG, 32'h0000_0100, "mode_lock");
		chk("is_output_lock", is_out, 2'h1);
		wr(OFF_CH_EN, 32'h0);
		// Every filter code: latency spans N samples plus strobe phase.
		for (int i = 0; i < 16; i++) begin
			wr(OFF_CAP_CFG, {24'h0, i[3:0], 4'h1});
			wr(OFF_CH_EN, 32'h0000_0100);
			lvl <= 3'h1;
			wait_ev((flen(i[3:0]) - 1) * fdiv(i[3:0]) + 1, flen(i[3:0]) * fdiv(i[3:0]) + 4);
			lvl <= 3'h0;
			repeat (flen(i[3:0]) * fdiv(i[3:0]) + 6) @(posedge clk);
			wr(OFF_CH_EN, 32'h0);
		end
		wr(OFF_CAP_CFG, 32'h0000_0031);
		wr(OFF_CH_EN, 32'h0000_0100);
		b0 = ev0;
		lvl <= 3'h1;
		repeat (5) @(posedge clk);
		lvl <= 3'h0;
		@(posedge clk);
		lvl <= 3'h1;
		repeat (5) @(posedge clk);
		lvl <= 3'h0;
		repeat (12) @(posedge clk);
		chk("filter_restart", ev0 - b0, 32'h0);
		wr(OFF_CH_EN, 32'h0);
		for (int d = 0; d < 4; d++) begin
			rnd = lfsr(rnd);
			n = rnd[3:0] + 1;
			wr(OFF_CAP_CFG, {28'h0, d[1:0], 2'h1});
			wr(OFF_CH_EN, 32'h0000_0100);
			b0 = ev0;
			edges(3'h1, n);
			chk("prescaled_events", ev0 - b0, n >> d);
			wr(OFF_CH_EN, 32'h0);
		end
		wr(OFF_CAP_CFG, 32'h0000_0001);
		lvl <= 3'h1;
		repeat (4) @(posedge clk);
		wr(OFF_CH_EN, 32'h0000_0300);
		b0 = ev0;
		lvl <= 3'h0;
		repeat (6) @(posedge clk);
		chk("falling_event", ev0 - b0, 32'h1);
		chk("inverted_level", sel[0], 1'b1);
		wr(OFF_CH_EN, 32'h0);
		wr(OFF_CAP_CFG, 32'h0000_0102);
		wr(OFF_CH_EN, 32'h0000_1100);
		b0 = ev0;
		b1 = ev1;
		edges(3'h2, 1);
		chk("cross_event", ev0 - b0, 32'h1);
		chk("ch3_event", ev1 - b1, 32'h1);
		wr(OFF_CH_EN, 32'h0);
		wr(OFF_CAP_CFG, 32'h0000_0103);
		wr(OFF_CH_EN, 32'h0000_0100);
		b0 = ev0;
		edges(3'h4, 2);
		chk("trigger_events", ev0 - b0, 32'h2);
		// Dead-time tick slowed to one in eight: the unfiltered path waits for it.
		wr(OFF_CH_EN, 32'h0);
		wr(OFF_MISC_CTRL, 32'h0000_0003);
		rd_chk(OFF_MISC_CTRL, 32'h0000_0003, "misc_rate");
		wr(OFF_CAP_CFG, 32'h0000_0001);
		wr(OFF_CH_EN, 32'h0000_0100);
		lvl <= 3'h1;
		wait_ev(5, 12);
		lvl <= 3'h0;
		repeat (20) @(posedge clk);
		finish_test();
	end
endmodule : timer_input_capture_conditioning_tb_top

// file: src/capture_cond_pkg.sv
// Purpose: Shared constants and types for the capture input conditioning block.
// Assumes: One 20 MHz kernel clock; registers reached over a plain strobe port.
// Notes:   Register offsets are byte addresses on the plain register port.
package capture_cond_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int            ADDR_W        = 8;
	localparam int            DATA_W        = 32;
	localparam logic [7:0]    OFF_MISC_CTRL = 8'h18;
	localparam logic [7:0]    OFF_CAP_CFG   = 8'h1C;
	localparam logic [7:0]    OFF_CH_EN     = 8'h20;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int            CFG_W         = 16;
	localparam int            CH_CFG_W      = 8;
	localparam int            IO_LSB        = 0;
	localparam int            EN_W          = 14;
	localparam int            EN_CH2_ON     = 8;
	localparam int            EN_CH2_POL    = 9;
	localparam int            EN_CH_STRIDE  = 4;
	localparam int            MISC_W        = 2;
	localparam logic [15:0]   CFG_RESET     = 16'h0000;
	localparam logic [13:0]   EN_RESET      = 14'h0000;
	localparam logic [1:0]    MISC_RESET    = 2'h0;

	// ----------------------------------------------------------------
	// Sampling rates: 0 is the kernel clock, 1 the dead-time tick,
	// and 2..6 the dead-time tick divided by 2, 4, 8, 16 and 32.
	// ----------------------------------------------------------------
	localparam int            RATE_N        = 7;
	localparam logic [2:0]    RATE_TIMER    = 3'h0;
	localparam logic [2:0]    RATE_DTS      = 3'h1;
	localparam logic [2:0]    RATE_DTS_2    = 3'h2;
	localparam logic [2:0]    RATE_DTS_4    = 3'h3;
	localparam logic [2:0]    RATE_DTS_8    = 3'h4;
	localparam logic [2:0]    RATE_DTS_16   = 3'h5;
	localparam logic [2:0]    RATE_DTS_32   = 3'h6;
	localparam int            SLOW_W        = 5;
	localparam int            DTS_CNT_W     = 3;

	typedef enum logic [1:0] {
		IO_OUTPUT = 2'h0,
		IO_OWN    = 2'h1,
		IO_CROSS  = 2'h2,
		IO_TRIG   = 2'h3
	} io_sel_t;

	// Per-channel slice of the capture configuration, in register order.
	typedef struct packed {
		logic [3:0] filter_code;
		logic [1:0] edge_divider;
		io_sel_t    io_select;
	} ch_cfg_t;

	function automatic logic [2:0] filt_rate(input logic [3:0] code);
		unique case (code)
			4'h0:                   filt_rate = RATE_DTS;
			4'h1, 4'h2, 4'h3:       filt_rate = RATE_TIMER;
			4'h4, 4'h5:             filt_rate = RATE_DTS_2;
			4'h6, 4'h7:             filt_rate = RATE_DTS_4;
			4'h8, 4'h9:             filt_rate = RATE_DTS_8;
			4'hA, 4'hB, 4'hC:       filt_rate = RATE_DTS_16;
			default:                filt_rate = RATE_DTS_32;
		endcase
	endfunction : filt_rate

	function automatic logic [3:0] filt_len(input logic [3:0] code);
		unique case (code)
			4'h0:                   filt_len = 4'h1;
			4'h1:                   filt_len = 4'h2;
			4'h2:                   filt_len = 4'h4;
			4'hA, 4'hD:             filt_len = 4'h5;
			4'h4, 4'h6, 4'h8, 4'hB,
			4'hE:                   filt_len = 4'h6;
			default:                filt_len = 4'h8;
		endcase
	endfunction : filt_len

endpackage : capture_cond_pkg

// file: src/input_sample_filter.sv
// Purpose: Event-counting digital filter for one capture input.
// Assumes: Input is synchronous to clk; sample_en is a strobe, held high every cycle at the kernel-clock rate.
// Notes:   Output moves only after run_len consecutive samples at the new level.
`timescale 1ns/100ps
module input_sample_filter
	import capture_cond_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       sample_en,
	input  wire logic [3:0] run_len,
	input  wire logic       raw_in,
	output logic            filt_out
);

	logic [3:0] run_q;
	logic [3:0] run_d;
	logic       filt_d;
	logic       differs;
	logic       run_done;
	logic [3:0] run_inc;

	// ----------------------------------------------------------------
	// Event counter
	// ----------------------------------------------------------------
	assign differs  = raw_in != filt_out;
	assign run_inc  = run_q + 4'h1;
	assign run_done = differs && (run_inc >= run_len);

	// A sample back at the settled level breaks the run, so glitches
	// shorter than run_len samples never reach the output.
	assign run_d  = !sample_en ? run_q :
	                (!differs || run_done) ? 4'h0 : run_inc;
	assign filt_d = (sample_en && run_done) ? raw_in : filt_out;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q    <= 4'h0;
			filt_out <= 1'b0;
		end else begin
			run_q    <= run_d;
			filt_out <= filt_d;
		end
	end

endmodule : input_sample_filter

// file: src/timer_input_capture_conditioning.sv
// Purpose: Input conditioning for timer capture channels 2 and 3.
// Assumes: Inputs synchronous to clk (20 MHz); plain strobe register port.
// Notes:   Capture latching, flags and output compare live elsewhere.
//
// Overview of operation
// - Channel 2 input passes event-counter filter.
// - Code 0 unfiltered at dts; 1-3 timer clock.
// - Codes 4-9: dts/2,/4,/8 with N 6/8.
// - Codes 10-15: dts/16,/32 with N 5/6/8.
// - Prescaler captures every 1, 2, 4, 8 edges.
// - Clearing channel enable resets prescaler counter.
// - Channel 3 fields at 15:12, 11:10, same decode.
// - Mode fields at 1:0 and 9:8.
// - Mode: output, own, neighbour, or internal trigger.
// - Mode field writable only while channel disabled.
// - Enable register at 0x20, resets to zero.
// - Enable register: four bits per channel; channel 3 has only bits 13:12.
// - Bit 11 holds channel 2 complementary polarity.
// - Polarity 1 inverts input, falling edge active.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
module timer_input_capture_conditioning
	import capture_cond_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                arst_n,
	input  wire logic [ADDR_W-1:0]   reg_addr,
	input  wire logic [DATA_W-1:0]   reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic [DATA_W-1:0]        reg_rdata,
	input  wire logic                ch2_raw_input,
	input  wire logic                ch3_raw_input,
	input  wire logic                internal_trigger_input,
	output logic [1:0]               selected_input,
	output logic [1:0]               capture_event,
	output logic [1:0]               channel_is_output,
	output logic [EN_W-1:0]          channel_enable_polarity
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta_q;
	logic rst_n;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	logic [CFG_W-1:0]   cap_cfg_q;
	logic [CFG_W-1:0]   cap_cfg_d;
	logic [CFG_W-1:0]   cfg_wmask;
	logic [MISC_W-1:0]  misc_q;
	logic [MISC_W-1:0]  misc_d;
	logic [EN_W-1:0]    en_d;
	logic               hit_cfg;
	logic               hit_en;
	logic               hit_misc;
	logic               wr_cfg;
	logic               wr_en;
	logic               wr_misc;
	logic [DATA_W-1:0]  rd_mux;
	logic [DATA_W-1:0]  rdata_d;
	logic [1:0]         ch_on;
	logic [1:0]         ch_pol;

	assign hit_cfg  = reg_addr == OFF_CAP_CFG;
	assign hit_en   = reg_addr == OFF_CH_EN;
	assign hit_misc = reg_addr == OFF_MISC_CTRL;
	assign wr_cfg   = reg_wr && hit_cfg;
	assign wr_en    = reg_wr && hit_en;
	assign wr_misc  = reg_wr && hit_misc;

	// A running channel keeps its mode; the rest of its slice still
	// takes the write, so filters can be retuned on the fly.
	assign cfg_wmask = {
		8'hFF & {{6{1'b1}}, {2{~ch_on[1]}}},
		8'hFF & {{6{1'b1}}, {2{~ch_on[0]}}}
	};

	assign cap_cfg_d = wr_cfg ?
		((reg_wdata[CFG_W-1:0] & cfg_wmask) | (cap_cfg_q & ~cfg_wmask)) :
		cap_cfg_q;
	// Bits above the implemented width are dropped; they read as zero.
	assign en_d      = wr_en ? reg_wdata[EN_W-1:0] : channel_enable_polarity;
	assign misc_d    = wr_misc ? reg_wdata[MISC_W-1:0] : misc_q;

	assign rd_mux  = hit_cfg  ? {{(DATA_W-CFG_W){1'b0}}, cap_cfg_q} :
	                 hit_en   ? {{(DATA_W-EN_W){1'b0}}, channel_enable_polarity} :
	                 hit_misc ? {{(DATA_W-MISC_W){1'b0}}, misc_q} :
	                 {DATA_W{1'b0}};
	assign rdata_d = reg_rd ? rd_mux : {DATA_W{1'b0}};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_cfg_q               <= CFG_RESET;
			channel_enable_polarity <= EN_RESET;
			misc_q                  <= MISC_RESET;
			reg_rdata               <= 32'h0000_0000;
		end else begin
			cap_cfg_q               <= cap_cfg_d;
			channel_enable_polarity <= en_d;
			misc_q                  <= misc_d;
			reg_rdata               <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Dead-time tick and sampling strobes
	// ----------------------------------------------------------------
	logic [DTS_CNT_W-1:0] dts_cnt_q;
	logic [DTS_CNT_W-1:0] dts_cnt_d;
	logic [DTS_CNT_W-1:0] dts_limit;
	logic                 dts_tick;
	logic [SLOW_W-1:0]    slow_q;
	logic [SLOW_W-1:0]    slow_d;
	logic [RATE_N-1:0]    rate_tick;

	assign dts_limit = DTS_CNT_W'((4'h1 << misc_q) - 4'h1);
	assign dts_tick  = dts_cnt_q == dts_limit;
	assign dts_cnt_d = dts_tick ? {DTS_CNT_W{1'b0}} : dts_cnt_q + 3'h1;
	assign slow_d    = dts_tick ? slow_q + 5'h01 : slow_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dts_cnt_q <= {DTS_CNT_W{1'b0}};
			slow_q    <= {SLOW_W{1'b0}};
		end else begin
			dts_cnt_q <= dts_cnt_d;
			slow_q    <= slow_d;
		end
	end

	assign rate_tick[RATE_TIMER] = 1'b1;
	assign rate_tick[RATE_DTS]   = dts_tick;

	// Each slower strobe fires on a dead-time tick seen while the low
	// bits of the shared counter are zero, so all rates stay phase-aligned.
	genvar r;
	generate
		for (r = 2; r < RATE_N; r++) begin : g_rate
			localparam logic [SLOW_W-1:0] MASK = SLOW_W'((1 << (r - 1)) - 1);
			assign rate_tick[r] = dts_tick && ((slow_q & MASK) == '0);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Per-channel filter, selection, polarity and edge prescaler
	// ----------------------------------------------------------------
	logic [1:0] raw_in;
	logic [1:0] filt;

	assign raw_in = {ch3_raw_input, ch2_raw_input};

	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_ch
			ch_cfg_t    cfg;
			logic [2:0] rate;
			logic [3:0] run_len;
			logic       pick;
			logic       sig_d;
			logic       sig_q;
			logic       act_edge;
			logic       is_input;
			logic [2:0] psc_q;
			logic [2:0] psc_d;
			logic [2:0] psc_top;
			logic       psc_hit;
			logic       evt_d;

			assign cfg     = ch_cfg_t'(cap_cfg_q[c*CH_CFG_W +: CH_CFG_W]);
			assign ch_on[c]  = channel_enable_polarity[EN_CH2_ON + c*EN_CH_STRIDE];
			assign ch_pol[c] = channel_enable_polarity[EN_CH2_POL + c*EN_CH_STRIDE];
			assign rate    = filt_rate(cfg.filter_code);
			assign run_len = filt_len(cfg.filter_code);

			input_sample_filter u_filter (
				.clk       (clk),
				.rst_n     (rst_n),
				.sample_en (rate_tick[rate]),
				.run_len   (run_len),
				.raw_in    (raw_in[c]),
				.filt_out  (filt[c])
			);

			assign is_input = cfg.io_select != IO_OUTPUT;
			assign pick = (cfg.io_select == IO_CROSS) ? filt[1-c] :
			              (cfg.io_select == IO_TRIG) ? internal_trigger_input :
			              filt[c];

			// Inverting first makes a falling input a rising edge here.
			assign sig_d    = pick ^ ch_pol[c];
			assign act_edge = sig_d && !sig_q;

			assign psc_top = 3'((4'h1 << cfg.edge_divider) - 4'h1);
			assign psc_hit = is_input && act_edge && (psc_q == psc_top);
			assign psc_d   = !ch_on[c] ? 3'h0 :
			                 psc_hit ? 3'h0 :
			                 (is_input && act_edge) ? psc_q + 3'h1 : psc_q;
			assign evt_d   = ch_on[c] && psc_hit;

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					sig_q                <= 1'b0;
					psc_q                <= 3'h0;
					capture_event[c]     <= 1'b0;
					channel_is_output[c] <= 1'b1;
				end else begin
					sig_q                <= sig_d;
					psc_q                <= psc_d;
					capture_event[c]     <= evt_d;
					channel_is_output[c] <= !is_input;
				end
			end

			assign selected_input[c] = sig_q;
		end
	endgenerate

endmodule : timer_input_capture_conditioning
